// ### scc_crc_lfsr.sv
// Serial checksum accumulator, one data bit per shift
`timescale 1ns/100ps
module scc_crc_lfsr (
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              clear,
  input  wire scc_pkg::scc_bit_s shiftBit,
  input  wire logic              wideFrame,
  input  wire logic [15:0]       poly,
  output logic      [15:0]       crcValue
);

  scc_pkg::scc_lfsr_s s_q;
  scc_pkg::scc_lfsr_s s_d;

  // Next value: shift left, fold feedback through taps
  always_comb begin
    logic        fb;
    logic [3:0]  msb;
    logic [15:0] shifted;
    logic [15:0] taps;
    s_d     = s_q;
    msb     = wideFrame ? scc_pkg::CRC_MSB_WIDE : scc_pkg::CRC_MSB_NARROW;
    fb      = s_q.crc[msb] ^ shiftBit.data;
    shifted = {s_q.crc[14:0], 1'b0};
    taps    = poly;
    if (!wideFrame) begin
      // Narrow frames keep only the low byte live
      shifted = shifted & scc_pkg::NARROW_MASK;
      taps    = taps & scc_pkg::NARROW_MASK;
    end
    if (clear) begin
      s_d.crc = scc_pkg::CRC_RESET;
    end else if (shiftBit.valid) begin
      s_d.crc = fb ? (shifted ^ taps) : shifted;
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q.crc <= scc_pkg::CRC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign crcValue = s_q.crc;

endmodule

// ### scc_pkg.sv
// Constants, field layouts and carrier types of the checksum and audio configuration block
package scc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_POLY    = 8'h10;
  localparam logic [7:0] OFS_RX_CRC  = 8'h14;
  localparam logic [7:0] OFS_TX_CRC  = 8'h18;
  localparam logic [7:0] OFS_CTRL    = 8'h1C;
  localparam logic [7:0] OFS_STATUS  = 8'h24;

  // Reset values
  localparam logic [15:0] POLY_RESET = 16'h0007;
  localparam logic [15:0] CRC_RESET  = 16'h0000;

  // Checksum geometry
  localparam logic [3:0]  CRC_MSB_WIDE   = 4'hF;
  localparam logic [3:0]  CRC_MSB_NARROW = 4'h7;
  localparam logic [15:0] NARROW_MASK    = 16'h00FF;

  // Status register bit positions
  localparam int STAT_MISMATCH_BIT = 0;
  localparam int STAT_ACTIVE_BIT   = 1;

  // Control field codes
  localparam logic [1:0] STD_PHILIPS = 2'h0;
  localparam logic [1:0] STD_MSB     = 2'h1;
  localparam logic [1:0] STD_LSB     = 2'h2;
  localparam logic [1:0] STD_PCM     = 2'h3;
  localparam logic [1:0] ROLE_SLAVE_TX  = 2'h0;
  localparam logic [1:0] ROLE_SLAVE_RX  = 2'h1;
  localparam logic [1:0] ROLE_MASTER_TX = 2'h2;
  localparam logic [1:0] ROLE_MASTER_RX = 2'h3;
  localparam logic [1:0] LEN_16 = 2'h0;
  localparam logic [1:0] LEN_24 = 2'h1;
  localparam logic [1:0] LEN_32 = 2'h2;
  localparam logic [1:0] LEN_RESERVED = 2'h3;

  // Control word, laid out exactly as bits 11:0 of the register
  typedef struct packed {
    logic       audioModeSelect;
    logic       audioEnable;
    logic [1:0] audioRoleSelect;
    logic       frameSyncLength;
    logic       padBit;
    logic [1:0] audioStandardSelect;
    logic       clockIdleLevel;
    logic [1:0] sampleLength;
    logic       slotLength;
  } scc_ctrl_s;

  localparam scc_ctrl_s CTRL_RESET = 12'h000;

  // One shifted serial bit
  typedef struct packed {
    logic valid;
    logic data;
  } scc_bit_s;

  // Accumulator state
  typedef struct packed {
    logic [15:0] crc;
  } scc_lfsr_s;

  // Top-level state
  typedef struct packed {
    logic [15:0] poly;
    scc_ctrl_s   ctrl;
    logic        effEnable;
    logic        effSyncLong;
    logic        mismatch;
    logic        active;
    logic        enPrev;
    logic [31:0] rdata;
  } scc_state_s;

endpackage

// ### scc_serial_peer.sv
// Behavioural serial peer that shifts one frame of bits into the block
`timescale 1ns/100ps
module scc_serial_peer (
  input  wire logic         clock,
  input  wire logic         start,
  input  wire logic [15:0]  word,
  input  wire logic         wide,
  input  wire logic         lsbFirst,
  output scc_pkg::scc_bit_s bitOut,
  output logic              busy
);
  int n;
  initial begin
    bitOut = 2'h1;
    busy = 1'b0;
  end
  // One bit a cycle; line flips after the frame so a stale bit never looks held
  always @(posedge clock) begin
    if (start) begin
      n = wide ? 16 : 8;
      busy <= 1'b1;
      for (int i = 0; i < n; i++) begin
        bitOut <= {1'b1, word[lsbFirst ? i : n - 1 - i]};
        @(posedge clock);
      end
      bitOut <= {1'b0, ~bitOut.data};
      busy <= 1'b0;
    end
  end
endmodule

// ### scc_sva.sv
// Port-level properties of the checksum and audio control block
`timescale 1ns/100ps
module scc_sva (
  input wire logic              clock,
  input wire logic              arst_n,
  input wire logic              regRd,
  input wire logic [31:0]       regRdata,
  input wire logic              frameShifting,
  input wire logic              transfer_active,
  input wire logic              peripheral_reset,
  input wire logic              checksum_enable,
  input wire logic              wideFrame,
  input wire scc_pkg::scc_bit_s rxBit,
  input wire logic [15:0]       poly_value,
  input wire logic [15:0]       rx_checksum_value,
  input wire logic [15:0]       tx_checksum_value,
  input wire logic              audio_mode_select,
  input wire logic              audio_enable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // Status mirror trails the engine by one cycle
  a_active_lag: assert property (transfer_active == $past(frameShifting))
    else $error("activity flag lag wrong");
  // Read bus stays quiet so idle reads cannot alias
  a_read_quiet: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside read slot");
  a_enable_clear: assert property ($rose(checksum_enable) |=>
    rx_checksum_value == 16'h0 && tx_checksum_value == 16'h0)
    else $error("enable did not clear checksums");
  a_reset_clear: assert property (peripheral_reset |=>
    rx_checksum_value == 16'h0 && tx_checksum_value == 16'h0)
    else $error("peripheral reset did not clear checksums");
  a_hold_off: assert property (!checksum_enable && !peripheral_reset |=>
    $stable(rx_checksum_value) && $stable(tx_checksum_value))
    else $error("checksum moved while disabled");
  // One fold per valid bit, masked polynomial taps
  a_rx_fold: assert property (
    rxBit.valid && wideFrame && checksum_enable && $past(checksum_enable) && !peripheral_reset
    |=> rx_checksum_value == (($past(rx_checksum_value) << 1)
    ^ ({16{$past(rx_checksum_value[15]) ^ $past(rxBit.data)}} & $past(poly_value))))
    else $error("wide receive fold wrong");
  a_narrow_zero: assert property (
    !wideFrame && rx_checksum_value[15:8] == 8'h00 |=> rx_checksum_value[15:8] == 8'h00)
    else $error("narrow checksum spilled into high byte");
  a_audio_gate: assert property (audio_enable |-> audio_mode_select)
    else $error("audio enabled in serial mode");
endmodule

bind scc_top scc_sva u_sva (.clock, .arst_n, .regRd, .regRdata, .frameShifting,
  .transfer_active, .peripheral_reset, .checksum_enable, .wideFrame, .rxBit, .poly_value,
  .rx_checksum_value, .tx_checksum_value, .audio_mode_select, .audio_enable);

// ### scc_top.sv
// Checksum accumulators, polynomial and audio control word with register port
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module scc_top (
  input  wire logic              clock,
  input  wire logic              arst_n,
  // Register port
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [31:0]       regRdata,
  // From the shift engine and control logic, same clock
  input  wire logic              peripheral_reset,
  input  wire logic              checksum_enable,
  input  wire logic              wideFrame,
  input  wire scc_pkg::scc_bit_s rxBit,
  input  wire scc_pkg::scc_bit_s txBit,
  input  wire logic              frameShifting,
  input  wire logic              crcCheckStrobe,
  input  wire logic [15:0]       rxCrcWord,
  // Status towards the rest of the peripheral
  output logic                   transfer_active,
  output logic                   checksum_mismatch_flag,
  output logic [15:0]            poly_value,
  output logic [15:0]            rx_checksum_value,
  output logic [15:0]            tx_checksum_value,
  // Audio configuration
  output logic                   audio_mode_select,
  output logic                   audio_enable,
  output logic [1:0]             audio_role_select,
  output logic                   frame_sync_length,
  output logic [1:0]             audio_standard_select,
  output logic                   clock_idle_level,
  output logic [1:0]             sample_length,
  output logic                   slot_length
);

  scc_pkg::scc_state_s s_q;
  scc_pkg::scc_state_s s_d;

  logic [15:0]        rxCrc;
  logic [15:0]        txCrc;
  logic               crcClear;
  scc_pkg::scc_bit_s  rxGated;
  scc_pkg::scc_bit_s  txGated;

  // Clear on the rising edge of checking or on peripheral reset
  assign crcClear = peripheral_reset | (checksum_enable & ~s_q.enPrev);

  // Bits only count while checking is enabled
  always_comb begin
    rxGated       = rxBit;
    txGated       = txBit;
    rxGated.valid = rxBit.valid & checksum_enable;
    txGated.valid = txBit.valid & checksum_enable;
  end

  // Receive accumulator
  scc_crc_lfsr u_rx_crc (
    .clock     (clock),
    .arst_n    (arst_n),
    .clear     (crcClear),
    .shiftBit  (rxGated),
    .wideFrame (wideFrame),
    .poly      (s_q.poly),
    .crcValue  (rxCrc)
  );

  // Transmit accumulator
  scc_crc_lfsr u_tx_crc (
    .clock     (clock),
    .arst_n    (arst_n),
    .clear     (crcClear),
    .shiftBit  (txGated),
    .wideFrame (wideFrame),
    .poly      (s_q.poly),
    .crcValue  (txCrc)
  );

  // Register writes, reads, status flags and derived controls
  always_comb begin
    logic        mismatchNow;
    logic [15:0] crcMask;
    logic        writeCtrl;
    logic        lockFields;
    scc_pkg::scc_ctrl_s wrCtrl;
    s_d         = s_q;
    crcMask     = wideFrame ? 16'hFFFF : scc_pkg::NARROW_MASK;
    mismatchNow = 1'b0;
    writeCtrl   = regWr & (regAddr == scc_pkg::OFS_CTRL);
    lockFields  = s_q.effEnable;
    wrCtrl      = scc_pkg::scc_ctrl_s'(regWdata[11:0]);
    s_d.enPrev  = checksum_enable;

    // Polynomial: only the low half-word is stored
    if (regWr && regAddr == scc_pkg::OFS_POLY) begin
      s_d.poly = regWdata[15:0];
    end

    // Control word; configuration fields held while audio runs
    if (writeCtrl) begin
      s_d.ctrl.audioEnable = wrCtrl.audioEnable;
      if (!lockFields) begin
        s_d.ctrl.audioModeSelect     = wrCtrl.audioModeSelect;
        s_d.ctrl.audioRoleSelect     = wrCtrl.audioRoleSelect;
        s_d.ctrl.frameSyncLength     = wrCtrl.frameSyncLength;
        s_d.ctrl.audioStandardSelect = wrCtrl.audioStandardSelect;
        s_d.ctrl.clockIdleLevel      = wrCtrl.clockIdleLevel;
        s_d.ctrl.sampleLength        = wrCtrl.sampleLength;
        s_d.ctrl.slotLength          = wrCtrl.slotLength;
      end
      s_d.ctrl.padBit = 1'b0;
    end

    // Enable only counts in audio mode; sync length only in PCM
    s_d.effEnable   = s_d.ctrl.audioEnable & s_d.ctrl.audioModeSelect;
    s_d.effSyncLong = s_d.ctrl.frameSyncLength
                    & (s_d.ctrl.audioStandardSelect == scc_pkg::STD_PCM);

    // Software clears the mismatch flag by writing zero
    if (regWr && regAddr == scc_pkg::OFS_STATUS && !regWdata[scc_pkg::STAT_MISMATCH_BIT]) begin
      s_d.mismatch = 1'b0;
    end
    // Set after clear so a coincident mismatch is kept
    if (crcCheckStrobe && checksum_enable && !s_q.ctrl.audioModeSelect) begin
      mismatchNow = ((rxCrc ^ rxCrcWord) & crcMask) != 16'h0000;
    end
    if (mismatchNow) begin
      s_d.mismatch = 1'b1;
    end

    // Shifting indication, any mode
    s_d.active = frameShifting;

    // Read data stand only in the cycle after the strobe
    s_d.rdata = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        scc_pkg::OFS_POLY:   s_d.rdata = {16'h0000, s_q.poly};
        scc_pkg::OFS_RX_CRC: s_d.rdata = {16'h0000, rxCrc};
        scc_pkg::OFS_TX_CRC: s_d.rdata = {16'h0000, txCrc};
        scc_pkg::OFS_CTRL:   s_d.rdata = {20'h00000, s_q.ctrl};
        scc_pkg::OFS_STATUS: begin
          s_d.rdata[scc_pkg::STAT_MISMATCH_BIT] = s_q.mismatch;
          s_d.rdata[scc_pkg::STAT_ACTIVE_BIT]   = s_q.active;
        end
        default:             s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q.poly        <= scc_pkg::POLY_RESET;
      s_q.ctrl        <= scc_pkg::CTRL_RESET;
      s_q.effEnable   <= 1'b0;
      s_q.effSyncLong <= 1'b0;
      s_q.mismatch    <= 1'b0;
      s_q.active      <= 1'b0;
      s_q.enPrev      <= 1'b0;
      s_q.rdata       <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign regRdata               = s_q.rdata;
  assign transfer_active        = s_q.active;
  assign checksum_mismatch_flag = s_q.mismatch;
  assign poly_value             = s_q.poly;
  assign rx_checksum_value      = rxCrc;
  assign tx_checksum_value      = txCrc;
  assign audio_mode_select      = s_q.ctrl.audioModeSelect;
  assign audio_enable           = s_q.effEnable;
  assign audio_role_select      = s_q.ctrl.audioRoleSelect;
  assign frame_sync_length      = s_q.effSyncLong;
  assign audio_standard_select  = s_q.ctrl.audioStandardSelect;
  assign clock_idle_level       = s_q.ctrl.clockIdleLevel;
  assign sample_length          = s_q.ctrl.sampleLength;
  assign slot_length            = s_q.ctrl.slotLength;

endmodule

// ### test_scc_top.sv
// Self-checking bench for the checksum and audio control block
`timescale 1ns/100ps
module test_scc_top;
  logic clock = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, start = 1'b0;
  logic peripheral_reset = 1'b0, checksum_enable = 1'b0, wideFrame = 1'b0, lsbFirst = 1'b0;
  logic crcCheckStrobe = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, d, p;
  logic [15:0] rxCrcWord = 16'h0, rxWord = 16'h0, txWord = 16'h0;
  logic [15:0] poly_value, rx_checksum_value, tx_checksum_value;
  logic [1:0]  audio_role_select, audio_standard_select, sample_length, v;
  logic        rxBusy, txBusy, transfer_active, checksum_mismatch_flag, audio_mode_select;
  logic        audio_enable, frame_sync_length, clock_idle_level, slot_length, frameShifting;
  scc_pkg::scc_bit_s rxBit, txBit;
  int fail_count = 0, checks = 0, cycles = 0, poly = 7, lastRx;

  assign frameShifting = rxBusy | txBusy;
  scc_top dut (.clock, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .peripheral_reset, .checksum_enable, .wideFrame, .rxBit, .txBit, .frameShifting,
    .crcCheckStrobe, .rxCrcWord, .transfer_active, .checksum_mismatch_flag, .poly_value,
    .rx_checksum_value, .tx_checksum_value, .audio_mode_select, .audio_enable,
    .audio_role_select, .frame_sync_length, .audio_standard_select, .clock_idle_level,
    .sample_length, .slot_length);
  scc_serial_peer rxPeer (.clock, .start, .word(rxWord), .wide(wideFrame), .lsbFirst,
    .bitOut(rxBit), .busy(rxBusy));
  scc_serial_peer txPeer (.clock, .start, .word(txWord), .wide(wideFrame), .lsbFirst,
    .bitOut(txBit), .busy(txBusy));

  initial forever #12.5 clock = ~clock;
  // Hang guard, run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] dat);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= dat;
    @(posedge clock);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, string name);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk(name, regRdata, exp);
  endtask
  // Reference shift-register checksum, bits taken in shift order
  function automatic int crcm(int w, int n, bit lsb);
    int c, m, b;
    c = 0;
    m = (n == 16) ? 32'h0000FFFF : 32'h000000FF;
    for (int i = 0; i < n; i++) begin
      b = lsb ? w[i] : w[n - 1 - i];
      c = ((c << 1) & m) ^ ((((c >> (n - 1)) & 1) ^ b) ? (poly & m) : 0);
    end
    return c;
  endfunction
  // Re-arm checking, then shift one random frame each way
  task automatic frame(bit wide, bit lsb);
    @(posedge clock);
    checksum_enable <= 1'b0;
    @(posedge clock);
    checksum_enable <= 1'b1;
    wideFrame <= wide;
    lsbFirst <= lsb;
    rxWord <= 16'($urandom);
    txWord <= 16'($urandom);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    #1;
    for (int k = 0; k < 20 && rxBusy !== 1'b0; k++) begin
      @(posedge clock);
      #1;
      if (k == 0) chk("transfer active", transfer_active, 1);
    end
    lastRx = crcm(rxWord, wide ? 16 : 8, lsb);
    chk("rx checksum", rx_checksum_value, lastRx);
    chk("tx checksum", tx_checksum_value, crcm(txWord, wide ? 16 : 8, lsb));
    rd(8'h14, lastRx, "rx checksum register");
  endtask

  initial begin
    void'($urandom(32'h94BA));
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd(8'h10, 32'h00000007, "poly reset");
    for (int a = 8'h14; a <= 8'h24; a += 4) rd(a[7:0], 32'h0, "reset value");
    d = $urandom;
    for (int a = 8'h10; a <= 8'h18; a += 4) wr(a[7:0], d);
    wr(8'h20, d);
    poly = d & 32'h0000FFFF;
    rd(8'h10, poly, "poly");
    chk("poly port", poly_value, poly);
    rd(8'h18, 32'h0, "tx checksum read only");
    rd(8'h20, 32'h0, "unmapped");
    // Every code of each field except audio enable (always 0) and frame sync length (always 1), reserved bits written as ones
    for (int i = 0; i < 4; i++) begin
      v = i[1:0];
      // Slot goes wide for any sample above 16 bits, never shorter than the sample
      p = {20'hFFFFF, v[0], 1'b0, v, 2'h3, v, v[0], v, |v};
      wr(8'h1C, p);
      chk("fields", {audio_mode_select, audio_role_select, frame_sync_length,
        audio_standard_select, clock_idle_level, sample_length, slot_length},
        {v[0], v, v == 2'h3, v, v[0], v, |v});
      rd(8'h1C, p & 32'h00000BBF, "control");
    end
    wr(8'h1C, 32'h00000C00);
    chk("audio on", audio_enable, 1);
    wr(8'h1C, 32'h00000C30);
    chk("standard locked", audio_standard_select, 0);
    wr(8'h1C, 32'h00000800);
    wr(8'h1C, 32'h00000400);
    chk("enable in serial mode", audio_enable, 0);
    rd(8'h1C, 32'h00000400, "control back");
    for (int f = 0; f < 4; f++) frame(f[1], f[0]);
    for (int e = 0; e < 2; e++) begin
      @(posedge clock);
      crcCheckStrobe <= 1'b1;
      rxCrcWord <= lastRx[15:0] ^ e[15:0];
      @(posedge clock);
      crcCheckStrobe <= 1'b0;
      #1 chk("mismatch flag", checksum_mismatch_flag, e);
    end
    wr(8'h24, 32'h0);
    rd(8'h24, 32'h0, "status cleared");
    @(posedge clock);
    peripheral_reset <= 1'b1;
    @(posedge clock);
    peripheral_reset <= 1'b0;
    #1 chk("checksums cleared", {rx_checksum_value, tx_checksum_value}, 0);
    // Shift a whole frame with checking off; gating must keep both at zero
    @(posedge clock);
    checksum_enable <= 1'b0;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (20) @(posedge clock);
    #1 chk("disabled hold", {rx_checksum_value, tx_checksum_value}, 0);
    tally_and_finish();
  end
endmodule
